/* shared/decoder_pkg.sv */
// Purpose: constants and types for the opcode decoder
// Assumes: 40 MHz ref_clk, byte-serial fetch stream
// Notes:   flag word bits not listed read as zero
package decoder_pkg;
  localparam logic [7:0]  ADR_FLAGS  = 8'h00;
  localparam logic [7:0]  ADR_STATUS = 8'h04;
  localparam logic [7:0]  ADR_COUNT  = 8'h08;
  localparam int          FL_CARRY   = 0;
  localparam int          FL_PARITY  = 2;
  localparam int          FL_AUX     = 4;
  localparam int          FL_ZERO    = 6;
  localparam int          FL_SIGN    = 7;
  localparam int          FL_TRAP    = 8;
  localparam int          FL_IRQ_EN  = 9;
  localparam int          FL_DIR     = 10;
  localparam int          FL_OVF     = 11;
  localparam logic [15:0] FLAGS_MASK  = 16'h0fd5;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [7:0]  OPC_LOCK      = 8'hf0;
  localparam logic [7:0]  OPC_CLR_CARRY = 8'hf8;
  localparam logic [7:0]  OPC_CMP_CARRY = 8'hf5;
  localparam logic [7:0]  OPC_SET_CARRY = 8'hf9;
  localparam logic [7:0]  OPC_CLR_DIR   = 8'hfc;
  localparam logic [7:0]  OPC_SET_DIR   = 8'hfd;
  localparam logic [7:0]  OPC_CLR_IRQ   = 8'hfa;
  localparam logic [7:0]  OPC_SET_IRQ   = 8'hfb;
  localparam logic [7:0]  OPC_TRAP_TYPE = 8'hcd;
  localparam logic [7:0]  OPC_TRAP_3    = 8'hcc;
  localparam logic [7:0]  OPC_TRAP_OVF  = 8'hce;
  localparam logic [7:0]  TRAP_TYPE_3   = 8'h03;
  localparam logic [7:0]  TRAP_TYPE_OVF = 8'h04;
  localparam logic [7:0]  SHIFT_ONE     = 8'h01;

  typedef enum logic [4:0] {
    OC_OTHER = 5'h00, OC_AND = 5'h01, OC_OR = 5'h02, OC_XOR = 5'h03,
    OC_TEST = 5'h04, OC_NOT = 5'h05, OC_ARITH = 5'h06, OC_SHIFT = 5'h07,
    OC_STRING = 5'h08, OC_JCC = 5'h09, OC_LOOP = 5'h0a, OC_EXIT = 5'h0b,
    OC_TRAP = 5'h0c, OC_FLAG = 5'h0d, OC_HALT = 5'h0e, OC_WAIT = 5'h0f,
    OC_EXTENSION = 5'h10, OC_BRANCH = 5'h11
  } op_class_e;

  typedef enum logic [2:0] {
    IMM_NONE = 3'b000, IMM_B = 3'b001, IMM_W = 3'b010,
    IMM_BYW = 3'b011, IMM_SW = 3'b100
  } imm_kind_e;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000, ST_MODRM = 3'b001, ST_DISP_LO = 3'b010,
    ST_DISP_HI = 3'b011, ST_IMM_LO = 3'b100, ST_IMM_HI = 3'b101,
    ST_EMIT = 3'b110
  } state_e;

  typedef struct packed {
    op_class_e op_class;
    logic      has_modrm;
    imm_kind_e imm_kind;
  } op_info_s;

  typedef struct packed {
    logic [15:0] base_register_b;
    logic [15:0] frame_base_pointer;
    logic [15:0] src_index;
    logic [15:0] dest_index_reg;
  } ea_regs_s;

  typedef struct packed {
    logic [7:0]  opcode;
    op_class_e   op_class;
    logic [2:0]  sub_op;
    logic        word;
    logic        to_reg;
    logic        rm_is_reg;
    logic [2:0]  reg_num;
    logic        reg_high;
    logic [2:0]  rm_num;
    logic        rm_high;
    logic [15:0] effective_location;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [7:0]  shift_count;
    logic [3:0]  cond;
    logic [7:0]  trap_type;
    logic        seg_valid;
    logic [1:0]  seg_code;
    logic        iterate_prefix;
    logic        iterate_sense;
    logic        iterate_go_on;
    logic        lock;
    logic [5:0]  ext_bits;
    logic        writes_result;
  } decoded_s;
endpackage

/* hdl/opcode_decoder.sv */
// Purpose: byte-serial opcode decoder with flag word and Wishbone registers
// Assumes: fetch stream and datapath share ref_clk
// Notes:   one decoded instruction per emit cycle
//
// Functional notes
// - addressing form 11: locator is a register number, no displacement
// - form 00 no disp, 01 one sign-extended byte, 10 low then high
// - locator 000 B+src, 001 B+dest, 010 frame+src, each plus disp
// - form 00 locator 110: direct 16-bit address from two bytes
// - displacement follows second byte, immediate follows displacement
// - transfer-sense 1: register is destination, 0: source
// - size bit 1 word, 0 byte, for width, registers, immediates
// - extend:size 01 word immediate, 11 byte sign-extended
// - shift count is one, or count_low_byte when count bit set
// - 110100vw group: select field picks rotate or shift kind
// - string primitives copy, compare, scan, load, store by size
// - iterate prefix repeats; compare/scan check sense against zero flag
// - 0111cccc conditional jump with one signed displacement byte
// - count branches 11100000-11100011 take one displacement byte
// - subroutine exits c3, c2 with word, cb, ca with word
// - traps: cd with type byte, cc type 3, ce on overflow, cf return
// - flag-control opcodes clear and set carry/direction/irq, complement carry only
// - halt f4, wait 9b, lock f0, extension 11011xxx plus addressing
// - 001ss110 prefix overrides segment of next memory access
// - register numbers: word registers, or low then high bytes
// - flag word is one 16-bit object with fixed bit layout
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module opcode_decoder
  import decoder_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  input  wire ea_regs_s    ea_regs,
  input  wire logic [7:0]  count_low_byte,
  output decoded_s         decoded,
  output logic             decoded_valid,
  output logic      [15:0] condition_flags_word
);

  ////////////////////////////////////////////////////////////////////
  // opcode tables
  function automatic op_info_s classify(input logic [7:0] b);
    op_info_s r;
    r = '{OC_OTHER, 1'b0, IMM_NONE};
    casez (b)
      8'b001000??: r = '{OC_AND, 1'b1, IMM_NONE};
      8'b000010??: r = '{OC_OR, 1'b1, IMM_NONE};
      8'b001100??: r = '{OC_XOR, 1'b1, IMM_NONE};
      8'b0010010?: r = '{OC_AND, 1'b0, IMM_BYW};
      8'b0000110?: r = '{OC_OR, 1'b0, IMM_BYW};
      8'b0011010?: r = '{OC_XOR, 1'b0, IMM_BYW};
      8'b1000010?: r = '{OC_TEST, 1'b1, IMM_NONE};
      8'b100000??: r = '{OC_ARITH, 1'b1, IMM_SW};
      8'b1111011?: r = '{OC_ARITH, 1'b1, IMM_NONE};
      8'b110100??: r = '{OC_SHIFT, 1'b1, IMM_NONE};
      8'b1010010?, 8'b1010011?, 8'b1010111?,
      8'b1010110?, 8'b1010101?: r = '{OC_STRING, 1'b0, IMM_NONE};
      8'b0111????: r = '{OC_JCC, 1'b0, IMM_B};
      8'b111000??: r = '{OC_LOOP, 1'b0, IMM_B};
      8'hc3, 8'hcb: r = '{OC_EXIT, 1'b0, IMM_NONE};
      8'hc2, 8'hca: r = '{OC_EXIT, 1'b0, IMM_W};
      8'hcd: r = '{OC_TRAP, 1'b0, IMM_B};
      8'hcc, 8'hce, 8'hcf: r = '{OC_TRAP, 1'b0, IMM_NONE};
      8'b1111100?, 8'b1111101?, 8'b1111110?,
      8'hf5: r = '{OC_FLAG, 1'b0, IMM_NONE};
      8'hf4: r = '{OC_HALT, 1'b0, IMM_NONE};
      8'h9b: r = '{OC_WAIT, 1'b0, IMM_NONE};
      8'b11011???: r = '{OC_EXTENSION, 1'b1, IMM_NONE};
      8'he8, 8'he9: r = '{OC_BRANCH, 1'b0, IMM_W};
      8'heb: r = '{OC_BRANCH, 1'b0, IMM_B};
      default: r = '{OC_OTHER, 1'b0, IMM_NONE};
    endcase
    return r;
  endfunction

  // group opcodes pick their operation from the select field
  function automatic op_info_s refine(input op_info_s i, input logic [7:0] op,
                                      input logic [2:0] sel);
    op_info_s r;
    r = i;
    if (op[7:2] == 6'b100000) begin
      unique case (sel)
        3'b100: r.op_class = OC_AND;
        3'b001: r.op_class = OC_OR;
        3'b110: r.op_class = OC_XOR;
        default: r.op_class = OC_ARITH;
      endcase
    end else if (op[7:1] == 7'b1111011) begin
      unique case (sel)
        3'b000: r = '{OC_TEST, 1'b1, IMM_BYW};
        3'b010: r.op_class = OC_NOT;
        default: r.op_class = OC_ARITH;
      endcase
    end
    return r;
  endfunction

  function automatic logic [1:0] imm_len(input imm_kind_e k, input logic [7:0] op);
    logic [1:0] n;
    n = 2'd0;
    unique case (k)
      IMM_B:   n = 2'd1;
      IMM_W:   n = 2'd2;
      IMM_BYW: n = op[0] ? 2'd2 : 2'd1;
      IMM_SW:  n = (op[1:0] == 2'b01) ? 2'd2 : 2'd1;
      default: n = 2'd0;
    endcase
    return n;
  endfunction

  function automatic logic [1:0] disp_len(input logic [7:0] m);
    logic [1:0] n;
    n = 2'd0;
    unique case (m[7:6])
      2'b00: n = (m[2:0] == 3'b110) ? 2'd2 : 2'd0;
      2'b01: n = 2'd1;
      2'b10: n = 2'd2;
      default: n = 2'd0;
    endcase
    return n;
  endfunction

  function automatic logic [15:0] ea_base(input logic [2:0] rm, input ea_regs_s r);
    logic [15:0] v;
    v = 16'h0000;
    unique case (rm)
      3'b000: v = r.base_register_b + r.src_index;
      3'b001: v = r.base_register_b + r.dest_index_reg;
      3'b010: v = r.frame_base_pointer + r.src_index;
      3'b011: v = r.frame_base_pointer + r.dest_index_reg;
      3'b100: v = r.src_index;
      3'b101: v = r.dest_index_reg;
      3'b110: v = r.frame_base_pointer;
      default: v = r.base_register_b;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state
  state_e      state;
  state_e      next_state;
  logic [7:0]  opcode_q;
  logic [7:0]  modrm_q;
  logic [7:0]  disp_lo;
  logic [7:0]  disp_hi;
  logic [7:0]  imm_lo;
  logic [7:0]  imm_hi;
  op_info_s    info_q;
  logic        seg_pend;
  logic [1:0]  seg_code_q;
  logic        iter_pend;
  logic        iter_sense_q;
  logic        lock_pend;
  logic [31:0] decode_count;
  logic [15:0] next_flags;
  decoded_s    next_decoded;

  ////////////////////////////////////////////////////////////////////
  // byte stream decode
  wire         take         = byte_valid & byte_ready;
  op_info_s    first_info;
  op_info_s    info_m;
  assign first_info = classify(byte_data);
  assign info_m     = refine(info_q, opcode_q, byte_data[5:3]);
  wire         is_seg       = (byte_data[7:5] == 3'b001) && (byte_data[2:0] == 3'b110);
  wire         is_iter      = (byte_data[7:1] == 7'b1111001);
  wire         is_lock      = (byte_data == OPC_LOCK);
  wire         is_prefix    = is_seg | is_iter | is_lock;
  wire [1:0]   first_imm    = imm_len(first_info.imm_kind, byte_data);
  wire [1:0]   modrm_imm    = imm_len(info_m.imm_kind, opcode_q);
  wire [1:0]   held_imm     = imm_len(info_q.imm_kind, opcode_q);
  wire [1:0]   modrm_disp   = disp_len(byte_data);
  wire [1:0]   held_disp    = disp_len(modrm_q);
  wire         has_imm      = (held_imm != 2'd0);
  wire         mode_reg     = info_q.has_modrm && (modrm_q[7:6] == 2'b11);
  wire         direct       = info_q.has_modrm && (modrm_q[7:6] == 2'b00)
                              && (modrm_q[2:0] == 3'b110);
  wire         word_op      = opcode_q[0];
  wire         sext_imm     = ((info_q.imm_kind == IMM_SW) && (opcode_q[1:0] == 2'b11))
                              || (info_q.op_class == OC_JCC)
                              || (info_q.op_class == OC_LOOP)
                              || (info_q.op_class == OC_BRANCH);
  wire [15:0]  disp_val     = (held_disp == 2'd2) ? {disp_hi, disp_lo} :
                              (held_disp == 2'd1) ? {{8{disp_lo[7]}}, disp_lo} :
                              16'h0000;
  wire [15:0]  imm_val      = (held_imm == 2'd2) ? {imm_hi, imm_lo} :
                              sext_imm ? {{8{imm_lo[7]}}, imm_lo} :
                              {8'h00, imm_lo};
  wire [15:0]  ea_val       = direct ? {disp_hi, disp_lo} :
                              16'(ea_base(modrm_q[2:0], ea_regs) + disp_val);
  wire         emit         = (state == ST_EMIT);
  wire [7:0]   trap_num     = (opcode_q == OPC_TRAP_TYPE) ? imm_lo :
                              (opcode_q == OPC_TRAP_3) ? TRAP_TYPE_3 :
                              (opcode_q == OPC_TRAP_OVF) ? TRAP_TYPE_OVF : 8'h00;
  wire         sense_check  = (info_q.op_class == OC_STRING) && opcode_q[1]
                              && (opcode_q[3:2] != 2'b10);
  wire         zf_now       = condition_flags_word[FL_ZERO];

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OPCODE: begin
        if (take && !is_prefix) begin
          if (first_info.has_modrm) next_state = ST_MODRM;
          else if (first_imm != 2'd0) next_state = ST_IMM_LO;
          else next_state = ST_EMIT;
        end
      end
      ST_MODRM: begin
        if (take) begin
          if (modrm_disp != 2'd0) next_state = ST_DISP_LO;
          else if (modrm_imm != 2'd0) next_state = ST_IMM_LO;
          else next_state = ST_EMIT;
        end
      end
      ST_DISP_LO: begin
        if (take) begin
          if (held_disp == 2'd2) next_state = ST_DISP_HI;
          else next_state = has_imm ? ST_IMM_LO : ST_EMIT;
        end
      end
      ST_DISP_HI: begin
        if (take) next_state = has_imm ? ST_IMM_LO : ST_EMIT;
      end
      ST_IMM_LO: begin
        if (take) next_state = (held_imm == 2'd2) ? ST_IMM_HI : ST_EMIT;
      end
      ST_IMM_HI: begin
        if (take) next_state = ST_EMIT;
      end
      ST_EMIT: next_state = ST_OPCODE;
      default: next_state = ST_OPCODE;
    endcase
  end

  always_comb begin
    next_decoded                    = '0;
    next_decoded.opcode             = opcode_q;
    next_decoded.op_class           = info_q.op_class;
    next_decoded.sub_op             = modrm_q[5:3];
    next_decoded.word               = word_op;
    next_decoded.to_reg             = opcode_q[1];
    next_decoded.rm_is_reg          = mode_reg;
    next_decoded.reg_num            = word_op ? modrm_q[5:3] : {1'b0, modrm_q[4:3]};
    next_decoded.reg_high           = !word_op && modrm_q[5];
    next_decoded.rm_num             = word_op ? modrm_q[2:0] : {1'b0, modrm_q[1:0]};
    next_decoded.rm_high            = !word_op && modrm_q[2];
    next_decoded.effective_location = mode_reg ? 16'h0000 : ea_val;
    next_decoded.disp               = disp_val;
    next_decoded.imm                = imm_val;
    next_decoded.shift_count        = opcode_q[1] ? count_low_byte : SHIFT_ONE;
    next_decoded.cond               = opcode_q[3:0];
    next_decoded.trap_type          = trap_num;
    next_decoded.seg_valid          = seg_pend;
    next_decoded.seg_code           = seg_code_q;
    next_decoded.iterate_prefix     = iter_pend;
    next_decoded.iterate_sense      = iter_sense_q;
    next_decoded.iterate_go_on      = iter_pend && (!sense_check || (iter_sense_q == zf_now));
    next_decoded.lock               = lock_pend;
    next_decoded.ext_bits           = {opcode_q[2:0], modrm_q[5:3]};
    next_decoded.writes_result      = (info_q.op_class != OC_TEST);
  end

  ////////////////////////////////////////////////////////////////////
  // flag word
  wire         bus_hit      = cyc_i & stb_i & !ack_o;
  wire         flags_write  = bus_hit & we_i & (adr_i == ADR_FLAGS);
  wire [15:0]  bus_flags    = {sel_i[1] ? dat_i[15:8] : condition_flags_word[15:8],
                               sel_i[0] ? dat_i[7:0] : condition_flags_word[7:0]};

  always_comb begin
    next_flags = condition_flags_word;
    if (emit && (info_q.op_class == OC_FLAG)) begin
      unique case (opcode_q)
        OPC_CLR_CARRY: next_flags[FL_CARRY]  = 1'b0;
        OPC_CMP_CARRY: next_flags[FL_CARRY]  = !condition_flags_word[FL_CARRY];
        OPC_SET_CARRY: next_flags[FL_CARRY]  = 1'b1;
        OPC_CLR_DIR:   next_flags[FL_DIR]    = 1'b0;
        OPC_SET_DIR:   next_flags[FL_DIR]    = 1'b1;
        OPC_CLR_IRQ:   next_flags[FL_IRQ_EN] = 1'b0;
        OPC_SET_IRQ:   next_flags[FL_IRQ_EN] = 1'b1;
        default:       next_flags = condition_flags_word;
      endcase
    end
    if (flags_write) next_flags = bus_flags;
    next_flags = next_flags & FLAGS_MASK;
  end

  ////////////////////////////////////////////////////////////////////
  // register read mux
  wire [31:0]  status_word  = {16'h0000, opcode_q, 2'b00, lock_pend, iter_pend,
                               seg_pend, state};
  wire [31:0]  rd_data      = (adr_i == ADR_FLAGS)  ? {16'h0000, condition_flags_word} :
                              (adr_i == ADR_STATUS) ? status_word :
                              (adr_i == ADR_COUNT)  ? decode_count : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      condition_flags_word <= FLAGS_RESET;
    end else begin
      ack_o <= bus_hit;
      dat_o <= bus_hit ? rd_data : 32'h0000_0000;
      condition_flags_word <= next_flags;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ST_OPCODE;
      byte_ready <= 1'b0;
      opcode_q   <= 8'h00;
      info_q     <= '{OC_OTHER, 1'b0, IMM_NONE};
    end else begin
      state      <= next_state;
      byte_ready <= (next_state != ST_EMIT);
      if (take && (state == ST_OPCODE) && !is_prefix) begin
        opcode_q <= byte_data;
        info_q   <= first_info;
      end else if (take && (state == ST_MODRM)) begin
        info_q   <= info_m;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      modrm_q <= 8'h00;
      disp_lo <= 8'h00;
      disp_hi <= 8'h00;
      imm_lo  <= 8'h00;
      imm_hi  <= 8'h00;
    end else begin
      if (take && (state == ST_OPCODE) && !is_prefix) begin
        modrm_q <= 8'h00;
        disp_lo <= 8'h00;
        disp_hi <= 8'h00;
        imm_lo  <= 8'h00;
        imm_hi  <= 8'h00;
      end
      if (take && (state == ST_MODRM))   modrm_q <= byte_data;
      if (take && (state == ST_DISP_LO)) disp_lo <= byte_data;
      if (take && (state == ST_DISP_HI)) disp_hi <= byte_data;
      if (take && (state == ST_IMM_LO))  imm_lo  <= byte_data;
      if (take && (state == ST_IMM_HI))  imm_hi  <= byte_data;
    end
  end

  // prefixes stay pending until the instruction they lead is emitted
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_pend     <= 1'b0;
      seg_code_q   <= 2'b00;
      iter_pend    <= 1'b0;
      iter_sense_q <= 1'b0;
      lock_pend    <= 1'b0;
    end else if (emit) begin
      seg_pend  <= 1'b0;
      iter_pend <= 1'b0;
      lock_pend <= 1'b0;
    end else if (take && (state == ST_OPCODE)) begin
      if (is_seg) begin
        seg_pend   <= 1'b1;
        seg_code_q <= byte_data[4:3];
      end
      if (is_iter) begin
        iter_pend    <= 1'b1;
        iter_sense_q <= byte_data[0];
      end
      if (is_lock) lock_pend <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      decoded       <= '0;
      decoded_valid <= 1'b0;
      decode_count  <= 32'h0000_0000;
    end else begin
      decoded_valid <= emit;
      if (emit) begin
        decoded      <= next_decoded;
        decode_count <= decode_count + 32'h0000_0001;
      end
    end
  end

endmodule // opcode_decoder

/* testbench/opcode_decoder_sva.sv */
// Purpose: port checks on the decoder
// Assumes: one clock domain
// Notes:   bound below
`timescale 1ns/1ps
module opcode_decoder_sva
  import decoder_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire decoded_s    decoded,
  input wire logic        decoded_valid,
  input wire logic [15:0] condition_flags_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence emit_of(logic [7:0] op);
    decoded_valid && decoded.opcode == op;
  endsequence
  ack_pulse_a: assert property (bus_req |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
  flag_mask_a: assert property ((condition_flags_word & ~FLAGS_MASK) == 16'h0000)
    else $error("undefined flag bit set");
  carry_set_a: assert property (emit_of(OPC_SET_CARRY) |-> condition_flags_word[FL_CARRY])
    else $error("carry not set");
  carry_clear_a: assert property (emit_of(OPC_CLR_CARRY) |-> !condition_flags_word[0])
    else $error("carry not cleared");
  carry_flip_a: assert property (emit_of(OPC_CMP_CARRY)
    |-> condition_flags_word[0] != $past(condition_flags_word[0]))
    else $error("carry not complemented");
  irq_set_a: assert property (emit_of(OPC_SET_IRQ) |-> condition_flags_word[9])
    else $error("irq enable not set");
  irq_clear_a: assert property (emit_of(OPC_CLR_IRQ) |-> !condition_flags_word[9])
    else $error("irq enable not cleared");
  dir_set_a: assert property (emit_of(OPC_SET_DIR) |-> condition_flags_word[10])
    else $error("direction not set");
endmodule // opcode_decoder_sva
bind opcode_decoder opcode_decoder_sva opcode_decoder_sva_inst (.ref_clk, .reset_n,
  .cyc_i, .stb_i, .ack_o, .decoded, .decoded_valid, .condition_flags_word);

/* testbench/fetch_queue_model.sv */
// Purpose: fetch queue offering bytes
// Assumes: bytes pushed by the bench
// Notes:   idle data shows inverse
`timescale 1ns/1ps
module fetch_queue_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       byte_ready,
  output logic            byte_valid,
  output logic      [7:0] byte_data
);
  logic [7:0] q[$];
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else if (!byte_valid || byte_ready) begin
      byte_valid <= q.size() > 0;
      byte_data  <= (q.size() > 0) ? q.pop_front() : ~byte_data;
    end
  end
endmodule // fetch_queue_model

/* testbench/tb_x86_16bit_opcode_decoder.sv */
// Purpose: self-checking decoder bench
// Assumes: queue model feeds bytes
// Notes:   ea regs held constant
`timescale 1ns/1ps
module tb_x86_16bit_opcode_decoder
  import decoder_pkg::*;
;
  logic        ref_clk, reset_n, cyc_i, stb_i, we_i, ack_o, byte_valid, byte_ready;
  logic        decoded_valid;
  logic [7:0]  adr_i, byte_data, count_low_byte;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, r;
  logic [15:0] condition_flags_word;
  ea_regs_s    ea_regs;
  decoded_s    decoded;
  int          failures = 0;
  int          tests_run = 0;
  int          runs = 0;
  opcode_decoder opcode_decoder_inst (.ref_clk, .reset_n, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .byte_valid, .byte_data, .byte_ready, .ea_regs,
    .count_low_byte, .decoded, .decoded_valid, .condition_flags_word);
  fetch_queue_model fetch_queue_model_inst (.ref_clk, .reset_n, .byte_ready, .byte_valid,
    .byte_data);
  ////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    r = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (ack_o !== 1'b1) failures++;
    if (ack_o !== 1'b1) give_verdict();
  endtask
  task automatic run(input logic [7:0] b[$]);
    int i;
    foreach (b[k]) fetch_queue_model_inst.push(b[k]);
    runs++;
    i = 0;
    do begin
      @(posedge ref_clk);
      #1;
      i++;
    end while (decoded_valid !== 1'b1 && i < 60);
    if (decoded_valid !== 1'b1) failures++;
    if (decoded_valid !== 1'b1) give_verdict();
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    {reset_n, cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
    sel_i = 4'hf;
    ea_regs = '{16'h1000, 16'h2000, 16'h0100, 16'h0200};
    count_low_byte = 8'h05;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    wb(1'b1, ADR_FLAGS, 32'hffff_ffff);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(r, 32'h0000_0fd5);
    wb(1'b1, ADR_FLAGS, 32'h0);
    run('{8'h20, 8'h40, 8'h80});
    chk({decoded.op_class, decoded.to_reg, decoded.word}, {OC_AND, 2'b00});
    chk({decoded.disp, decoded.effective_location}, 32'hff80_1080);
    run('{8'h22, 8'he7});
    chk({decoded.to_reg, decoded.word, decoded.reg_num, decoded.reg_high, decoded.rm_num,
      decoded.rm_high}, 10'h217);
    run('{8'h81, 8'h26, 8'h34, 8'h12, 8'h78, 8'h56});
    chk({decoded.effective_location, decoded.imm}, 32'h1234_5678);
    run('{8'h83, 8'hce, 8'hff});
    chk({decoded.op_class, decoded.rm_is_reg, decoded.imm}, {OC_OR, 17'h1ffff});
    run('{8'hd2, 8'he0});
    chk({decoded.op_class, decoded.sub_op, decoded.shift_count}, {OC_SHIFT, 11'h405});
    run('{8'hd1, 8'hf8});
    chk({decoded.op_class, decoded.sub_op, decoded.shift_count}, {OC_SHIFT, 11'h701});
    run('{8'h09, 8'h83, 8'h10, 8'h00});
    chk({decoded.op_class, decoded.word, decoded.effective_location}, {OC_OR, 17'h12210});
    run('{8'hf3, 8'ha6});
    chk({decoded.op_class, decoded.iterate_prefix, decoded.iterate_sense,
      decoded.iterate_go_on}, {OC_STRING, 3'b110});
    run('{8'h26, 8'ha4});
    chk({decoded.seg_valid, decoded.seg_code}, 3'b100);
    run('{8'h74, 8'hfe});
    chk({decoded.op_class, decoded.cond}, {OC_JCC, 4'h4});
    run('{8'he3, 8'h05});
    chk(decoded.op_class, OC_LOOP);
    run('{8'hc2, 8'h10, 8'h00});
    chk({decoded.op_class, decoded.imm}, {OC_EXIT, 16'h0010});
    run('{8'hcd, 8'h21});
    chk(decoded.trap_type, 8'h21);
    run('{8'hf0, 8'hcc});
    chk({decoded.lock, decoded.trap_type}, 9'h103);
    run('{8'hd9, 8'hc0});
    chk(decoded.op_class, OC_EXTENSION);
    run('{8'hf4});
    chk(decoded.op_class, OC_HALT);
    run('{8'h85, 8'hc0});
    chk({decoded.op_class, decoded.writes_result, decoded.word}, {OC_TEST, 2'b01});
    run('{8'hf9});
    run('{8'hfd});
    run('{8'hfb});
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(r, 32'h0000_0601);
    run('{8'hf5});
    run('{8'hfa});
    run('{8'hf8});
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(r, 32'h0000_0400);
    wb(1'b0, ADR_COUNT, 32'h0);
    chk(r, runs);
    give_verdict();
  end
endmodule // tb_x86_16bit_opcode_decoder
